/* mrsf_pkg.sv */
// Behaviour
// R01 - a bus idle of at least 3.5 character times ends a frame
// R02 - frame order: station address, function, payload, two check bytes
// R03 - station field holds 0 to 247; act on own address or broadcast
// R04 - addresses 1 to 247 are point-to-point; matching station executes and replies
// R05 - broadcast frames are executed but never answered
// R06 - a reply carries our own station address in its first byte
// R07 - support function 03h read word and 06h write word
// R08 - error reply returns the request function with 80h added
// R09 - bad addressed request gets an error reply and changes nothing
// R10 - good addressed request is executed, then answered with a normal reply
// R11 - never transmit except in answer to a request addressed to us
// R12 - half duplex: drive the bus only while we send
// R13 - check value goes out low byte first, then high byte
// R14 - other multi-byte fields go out high byte first
// R15 - recompute the check value; a mismatch marks the frame corrupt
// R16 - frame content is raw binary bytes, not text
// R17 - serial fault reset honoured only in remote mode with source select 2
// R18 - read rejects more than five words; reply gives byte count before data
// R19 - write reply is a byte copy of the request
// R20 - check value is crc16 init ffff, reflected poly a001, lsb first
// R21 - corrupt frames and frames for other stations are dropped silently
// R22 - gap timer runs from the baud setting, eleven bits per character
package mrsf_pkg;
   localparam int unsigned CHAR_BITS      = 11;
   localparam int unsigned GAP_HALF_CHARS = 7;
   localparam int unsigned BYTE_BITS      = 8;
   localparam logic [5:0]  GAP_BITS_LAST  = 6'((CHAR_BITS * GAP_HALF_CHARS + 1) / 2 - 1);
   localparam logic [7:0]  FN_READ        = 8'h03;
   localparam logic [7:0]  FN_WRITE       = 8'h06;
   localparam logic [7:0]  FN_ERR_FLAG    = 8'h80;
   localparam logic [7:0]  ADDR_BCAST     = 8'h00;
   localparam logic [7:0]  ADDR_MAX       = 8'hf7;
   localparam logic [15:0] RD_MAX_WORDS   = 16'h0005;
   localparam logic [3:0]  RX_LEN         = 4'h8;
   localparam logic [3:0]  RX_MIN         = 4'h4;
   localparam logic [3:0]  OFS_STA        = 4'h0;
   localparam logic [3:0]  OFS_FN         = 4'h1;
   localparam logic [3:0]  OFS_CNT        = 4'h2;
   localparam logic [3:0]  OFS_DATA       = 4'h3;
   localparam logic [3:0]  ERR_LEN        = 4'h3;
   localparam logic [3:0]  WR_LEN         = 4'h6;
   localparam logic [7:0]  ERR_NONE       = 8'h00;
   localparam logic [7:0]  ERR_FUNC       = 8'h01;
   localparam logic [7:0]  ERR_ADDR       = 8'h02;
   localparam logic [7:0]  ERR_VALUE      = 8'h03;
   localparam logic [7:0]  ERR_EXEC       = 8'h04;
   localparam logic [15:0] CRC_INIT       = 16'hffff;
   localparam logic [15:0] CRC_POLY       = 16'ha001;
   localparam logic [1:0]  CSS_SERIAL     = 2'h2;
   localparam logic [15:0] FAULT_RST_REG  = 16'h2000;
   localparam int unsigned TX_FIFO_DEPTH  = 8;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_ACCESS = 3'h1,
      ST_SEND   = 3'h3,
      ST_CRC_LO = 3'h2,
      ST_CRC_HI = 3'h6
   } mrsf_state_t;

   // one byte through the reflected crc, lsb first
   function automatic logic [15:0] mrsf_crc_step(input logic [15:0] crc,
                                                 input logic [7:0]  b);
      logic [15:0] c;
      c = crc ^ {8'h00, b};
      for (int i = 0; i < BYTE_BITS; i++) begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction
endpackage

/* mrsf_stream_if.sv */
`timescale 1ns/100ps
`default_nettype none
// byte stream with valid and ready
interface mrsf_stream_if #(parameter int unsigned WIDTH = 8);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;
   modport prod (output valid, output data, input ready);
   modport cons (input valid, input data, output ready);
endinterface
`default_nettype wire

/* mrsf_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module mrsf_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic   clk_in,
   input  wire logic   sys_rst_in,
   input  wire logic   ce_in,
   mrsf_stream_if.cons wr_if,
   mrsf_stream_if.prod rd_if
);
   // depth must be a power of two so the pointers wrap by themselves
   localparam int unsigned AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wp_q;
   logic [AW-1:0]    rp_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   // honest flags; a frozen fifo still reports its level
   assign wr_if.ready = cnt_q != FULL_CNT;
   assign rd_if.valid = cnt_q != '0;
   assign rd_if.data  = mem_q[rp_q];
   assign push        = ce_in && wr_if.valid && wr_if.ready;
   assign pop         = ce_in && rd_if.valid && rd_if.ready;

   // storage write
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_q[wp_q] <= wr_if.data;
      end
   end

   // pointers and level
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wp_q <= wp_q + 1'b1;
         if (pop) rp_q <= rp_q + 1'b1;
         cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end

   property p_fifo_no_overrun;
      @(posedge clk_in) disable iff (sys_rst_in)
         (cnt_q == FULL_CNT && !pop) |=> cnt_q == FULL_CNT;
   endproperty
   a_fifo_no_overrun: assert property (p_fifo_no_overrun)
      else $error("fifo level moved past full");

   property p_fifo_level;
      @(posedge clk_in) disable iff (sys_rst_in)
         (push && !pop) |=> cnt_q == $past(cnt_q) + 1'b1;
   endproperty
   a_fifo_level: assert property (p_fifo_level)
      else $error("push did not raise the level");
endmodule // mrsf_fifo
`default_nettype wire

/* mrsf_framer.sv */
`timescale 1ns/100ps
`default_nettype none
module mrsf_framer
   import mrsf_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        ce_in,
   input  wire logic [7:0]  own_addr_in,
   input  wire logic [15:0] baud_div_in,
   input  wire logic        rx_valid_in,
   input  wire logic [7:0]  rx_byte_in,
   output logic             tx_valid_out,
   output logic [7:0]       tx_byte_out,
   input  wire logic        tx_ready_in,
   input  wire logic        tx_busy_in,
   output logic             tx_en_out,
   input  wire logic        remote_mode_in,
   input  wire logic [1:0]  command_source_select_in,
   output logic             acc_valid_out,
   output logic             acc_write_out,
   output logic [15:0]      acc_addr_out,
   output logic [15:0]      acc_wdata_out,
   input  wire logic [15:0] acc_rdata_in,
   input  wire logic        acc_ok_in,
   output logic             wr_strobe_out,
   output logic             fault_reset_out
);
   // ****************************************
   // frame gap timer
   // ****************************************
   logic [15:0] div_q;
   logic [5:0]  gbits_q;
   logic        armed_q;
   logic        bit_end;
   logic        gap_fire;

   // a zero divider behaves as one clock per bit
   assign bit_end  = ({1'b0, div_q} + 17'h1) >= {1'b0, baud_div_in};
   // a byte in the same cycle restarts the gap instead of closing it
   assign gap_fire = armed_q && bit_end && gbits_q == GAP_BITS_LAST
                     && !rx_valid_in; // R01 R22

   // count whole bit periods since the last byte
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         armed_q <= 1'b0;
         div_q   <= '0;
         gbits_q <= '0;
      end else if (ce_in) begin
         if (rx_valid_in) begin
            armed_q <= 1'b1;
            div_q   <= '0;
            gbits_q <= '0;
         end else if (armed_q) begin
            div_q <= bit_end ? '0 : div_q + 16'h1;
            if (bit_end) begin
               gbits_q <= gbits_q + 6'h1; // R22
               if (gap_fire) armed_q <= 1'b0;
            end
         end
      end
   end

   // ****************************************
   // receive capture and check
   // ****************************************
   logic [7:0]  rx_buf_q [RX_LEN];
   logic [3:0]  rx_cnt_q;
   logic [15:0] rx_crc_q;

   // count saturates one past the buffer to flag an oversize frame
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         rx_cnt_q <= '0;
         rx_crc_q <= CRC_INIT;
      end else if (ce_in) begin
         if (rx_valid_in) begin
            if (rx_cnt_q <= RX_LEN) rx_cnt_q <= rx_cnt_q + 4'h1;
            rx_crc_q <= mrsf_crc_step(rx_crc_q, rx_byte_in); // R15 R20
         end else if (gap_fire) begin
            rx_cnt_q <= '0;
            rx_crc_q <= CRC_INIT;
         end
      end
   end

   // raw bytes land by position in the order they arrive
   for (genvar g = 0; g < RX_LEN; g++) begin : g_rxb
      always_ff @(posedge clk_in) begin
         if (ce_in && rx_valid_in && rx_cnt_q == 4'(g)) begin
            rx_buf_q[g] <= rx_byte_in; // R02 R16
         end
      end
   end

   logic [7:0]  r_sta;
   logic [7:0]  r_fn;
   logic [15:0] r_reg;
   logic [15:0] r_val;
   logic        frame_ok;
   logic        addr_hit;
   logic [7:0]  dec_code;

   // fields high byte first
   assign r_sta = rx_buf_q[0];
   assign r_fn  = rx_buf_q[1];
   assign r_reg = {rx_buf_q[2], rx_buf_q[3]}; // R14
   assign r_val = {rx_buf_q[4], rx_buf_q[5]}; // R14
   // crc over a frame including its own low-first check reads zero
   assign frame_ok = rx_cnt_q >= RX_MIN && rx_cnt_q <= RX_LEN
                     && rx_crc_q == '0; // R13 R15 R21
   assign addr_hit = r_sta == ADDR_BCAST
                     || (r_sta == own_addr_in && own_addr_in != ADDR_BCAST
                         && own_addr_in <= ADDR_MAX); // R03 R04 R21

   // request screening before anything is touched
   always_comb begin
      dec_code = ERR_NONE;
      if (r_fn != FN_READ && r_fn != FN_WRITE) begin
         dec_code = ERR_FUNC; // R07
      end else if (rx_cnt_q != RX_LEN) begin
         dec_code = ERR_VALUE;
      end else if (r_fn == FN_READ && (r_val == '0 || r_val > RD_MAX_WORDS)) begin
         dec_code = ERR_VALUE; // R18
      end
   end

   // ****************************************
   // execution and reply sequencing
   // ****************************************
   mrsf_state_t state_q;
   logic        bc_q;
   logic        err_q;
   logic [7:0]  fn_q;
   logic [7:0]  code_q;
   logic [15:0] reg_q;
   logic [15:0] val_q;
   logic [15:0] addr_q;
   logic [2:0]  k_q;
   logic [3:0]  idx_q;
   logic [3:0]  rlen_q;
   logic [15:0] tx_crc_q;
   logic [15:0] rd_q [RD_MAX_WORDS];
   logic        is_fault;
   logic        fault_ok;
   logic [7:0]  acc_code;
   logic        last_word;
   logic        take;
   logic        push_rdy;
   logic        push_fire;
   logic        push_valid;
   logic [7:0]  push_data;

   assign is_fault  = fn_q == FN_WRITE && reg_q == FAULT_RST_REG;
   assign fault_ok  = remote_mode_in && command_source_select_in == CSS_SERIAL; // R17
   assign last_word = fn_q == FN_WRITE || 16'(k_q) == val_q - 16'h1;
   assign take      = state_q == ST_IDLE && gap_fire && frame_ok && addr_hit;

   // a refused access leaves the application untouched
   always_comb begin
      acc_code = ERR_NONE;
      if (is_fault) begin
         if (!fault_ok) acc_code = ERR_EXEC; // R17
      end else if (!acc_ok_in) begin
         acc_code = fn_q == FN_WRITE ? ERR_EXEC : ERR_ADDR; // R09
      end
   end

   // main sequence; broadcasts skip the reply entirely
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_q <= ST_IDLE;
         bc_q    <= 1'b0;
         err_q   <= 1'b0;
         fn_q    <= '0;
         code_q  <= ERR_NONE;
         reg_q   <= '0;
         val_q   <= '0;
         addr_q  <= '0;
         k_q     <= '0;
         idx_q   <= '0;
         rlen_q  <= '0;
      end else if (ce_in) begin
         case (state_q)
            ST_IDLE: begin
               idx_q <= '0;
               k_q   <= '0;
               if (take) begin
                  bc_q   <= r_sta == ADDR_BCAST;
                  fn_q   <= r_fn;
                  reg_q  <= r_reg;
                  addr_q <= r_reg;
                  val_q  <= r_val;
                  code_q <= dec_code;
                  err_q  <= dec_code != ERR_NONE;
                  rlen_q <= ERR_LEN;
                  if (dec_code == ERR_NONE) state_q <= ST_ACCESS;
                  else if (r_sta != ADDR_BCAST) state_q <= ST_SEND; // R09
               end
            end
            ST_ACCESS: begin
               if (acc_code != ERR_NONE) begin
                  err_q   <= 1'b1;
                  code_q  <= acc_code;
                  rlen_q  <= ERR_LEN;
                  state_q <= bc_q ? ST_IDLE : ST_SEND; // R05 R09
               end else if (last_word) begin
                  rlen_q  <= fn_q == FN_WRITE ? WR_LEN
                             : OFS_DATA + {val_q[2:0], 1'b0}; // R18 R19
                  state_q <= bc_q ? ST_IDLE : ST_SEND; // R05 R10
               end else begin
                  k_q    <= k_q + 3'h1;
                  addr_q <= addr_q + 16'h1;
               end
            end
            ST_SEND: begin
               if (push_rdy) begin
                  idx_q <= idx_q + 4'h1;
                  if (idx_q == rlen_q - 4'h1) state_q <= ST_CRC_LO;
               end
            end
            ST_CRC_LO: if (push_rdy) state_q <= ST_CRC_HI; // R13
            ST_CRC_HI: if (push_rdy) state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // read words are kept for the reply
   always_ff @(posedge clk_in) begin
      if (ce_in && state_q == ST_ACCESS && fn_q == FN_READ && acc_ok_in) begin
         rd_q[k_q] <= acc_rdata_in; // R10
      end
   end

   // fault reset pulses once an allowed serial reset is executed
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         fault_reset_out <= 1'b0;
      end else if (ce_in) begin
         fault_reset_out <= state_q == ST_ACCESS && is_fault && fault_ok; // R17
      end
   end

   // application access; writes commit only when the target accepts
   assign acc_valid_out = state_q == ST_ACCESS && !is_fault;
   assign acc_write_out = fn_q == FN_WRITE;
   assign acc_addr_out  = addr_q;
   assign acc_wdata_out = val_q;
   assign wr_strobe_out = ce_in && acc_valid_out && acc_write_out && acc_ok_in; // R09

   // ****************************************
   // reply byte stream
   // ****************************************
   logic [3:0] didx;
   logic [2:0] wsel;

   assign didx = idx_q - OFS_DATA;
   assign wsel = didx[3:1];

   // reply bytes by position; data words high byte first
   always_comb begin
      push_data = 8'h00;
      case (state_q)
         ST_SEND: begin
            if (idx_q == OFS_STA) begin
               push_data = own_addr_in; // R06
            end else if (idx_q == OFS_FN) begin
               push_data = err_q ? (fn_q | FN_ERR_FLAG) : fn_q; // R08
            end else if (err_q) begin
               push_data = code_q;
            end else if (fn_q == FN_WRITE) begin
               case (idx_q)
                  4'h2: push_data = reg_q[15:8]; // R19
                  4'h3: push_data = reg_q[7:0];
                  4'h4: push_data = val_q[15:8];
                  default: push_data = val_q[7:0];
               endcase
            end else if (idx_q == OFS_CNT) begin
               push_data = {val_q[6:0], 1'b0}; // R18
            end else begin
               push_data = didx[0] ? rd_q[wsel][7:0] : rd_q[wsel][15:8]; // R14
            end
         end
         ST_CRC_LO: push_data = tx_crc_q[7:0]; // R13
         ST_CRC_HI: push_data = tx_crc_q[15:8];
         default: push_data = 8'h00;
      endcase
   end

   // only a taken request ever reaches these states
   assign push_valid = state_q == ST_SEND || state_q == ST_CRC_LO
                       || state_q == ST_CRC_HI; // R11
   assign push_fire  = ce_in && push_valid && push_rdy;

   // reply crc built alongside the bytes
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         tx_crc_q <= CRC_INIT;
      end else if (ce_in) begin
         if (state_q == ST_IDLE) tx_crc_q <= CRC_INIT;
         else if (push_fire && state_q == ST_SEND) begin
            tx_crc_q <= mrsf_crc_step(tx_crc_q, push_data); // R20
         end
      end
   end

   // eight bytes of slack lets the uart lag without stalling the sequence much
   mrsf_stream_if #(.WIDTH(8)) push_if ();
   mrsf_stream_if #(.WIDTH(8)) pop_if ();

   assign push_if.valid = push_valid;
   assign push_if.data  = push_data;
   assign push_rdy      = push_if.ready;
   assign pop_if.ready  = tx_ready_in;
   assign tx_valid_out  = pop_if.valid;
   assign tx_byte_out   = pop_if.data;

   mrsf_fifo #(.WIDTH(8), .DEPTH(TX_FIFO_DEPTH)) u_txq (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .ce_in      (ce_in),
      .wr_if      (push_if),
      .rd_if      (pop_if)
   );

   // driver enabled from first reply byte until the line is quiet again
   assign tx_en_out = push_valid || pop_if.valid || tx_busy_in; // R12

   // ****************************************
   // checks
   // ****************************************
   // clock count since the last byte, kept apart from the bit counter it checks
   logic [21:0] quiet_q;
   always_ff @(posedge clk_in) begin
      if (sys_rst_in || (ce_in && rx_valid_in)) begin
         quiet_q <= '0;
      end else if (ce_in && quiet_q != '1) begin
         quiet_q <= quiet_q + 22'h1;
      end
   end

   property p_gap_len;
      @(posedge clk_in) disable iff (sys_rst_in)
         gap_fire |-> quiet_q + 22'h1 == 22'(GAP_BITS_LAST + 1'b1)
                      * 22'(baud_div_in == '0 ? 16'h1 : baud_div_in);
   endproperty
   a_gap_len: assert property (p_gap_len) // R01
      else $error("gap closed before 3.5 characters");

   property p_drop_bad;
      @(posedge clk_in) disable iff (sys_rst_in)
         (state_q == ST_IDLE && ce_in && gap_fire && (rx_crc_q != '0 || !addr_hit))
         |=> state_q == ST_IDLE;
   endproperty
   a_drop_bad: assert property (p_drop_bad) // R21
      else $error("corrupt or foreign frame was acted on");

   property p_bcast_silent;
      @(posedge clk_in) disable iff (sys_rst_in)
         (state_q == ST_SEND) |-> !bc_q;
   endproperty
   a_bcast_silent: assert property (p_bcast_silent) // R05
      else $error("reply started for a broadcast");

   property p_only_on_request;
      @(posedge clk_in) disable iff (sys_rst_in)
         (state_q == ST_IDLE && !take) |=> state_q == ST_IDLE;
   endproperty
   a_only_on_request: assert property (p_only_on_request) // R11
      else $error("left idle without a request");

   property p_own_first;
      @(posedge clk_in) disable iff (sys_rst_in)
         (state_q == ST_SEND && idx_q == OFS_STA) |-> push_data == own_addr_in;
   endproperty
   a_own_first: assert property (p_own_first) // R06
      else $error("reply does not open with own address");

   property p_err_fn;
      @(posedge clk_in) disable iff (sys_rst_in)
         (state_q == ST_SEND && idx_q == OFS_FN && err_q)
         |-> push_data == (fn_q | FN_ERR_FLAG) && push_data[7];
   endproperty
   a_err_fn: assert property (p_err_fn) // R08
      else $error("error reply lacks flagged function");

   property p_write_guard;
      @(posedge clk_in) disable iff (sys_rst_in)
         wr_strobe_out |-> acc_ok_in && !is_fault && state_q == ST_ACCESS && !err_q;
   endproperty
   a_write_guard: assert property (p_write_guard) // R09
      else $error("write committed on a refused request");

   property p_crc_order;
      @(posedge clk_in) disable iff (sys_rst_in)
         (push_fire && state_q == ST_CRC_LO)
         |-> push_data == tx_crc_q[7:0] ##1 state_q == ST_CRC_HI;
   endproperty
   a_crc_order: assert property (p_crc_order) // R13
      else $error("check bytes out of order");

   property p_read_limit;
      @(posedge clk_in) disable iff (sys_rst_in)
         (state_q == ST_ACCESS && fn_q == FN_READ)
         |-> val_q != '0 && val_q <= RD_MAX_WORDS;
   endproperty
   a_read_limit: assert property (p_read_limit) // R18
      else $error("read of more than five words executed");
endmodule // mrsf_framer
`default_nettype wire

/* mrsf_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ************************************************
// host master model: request sender, reply uart
// ************************************************
module mrsf_host_model (
   input  wire logic clk_in,
   input  wire logic tx_valid_in,
   input  wire logic stall_in,
   output logic      rx_valid_out,
   output logic [7:0] rx_byte_out,
   output logic      tx_ready_out,
   output logic      tx_busy_out
);
   int busy_cnt = 0;
   initial begin
      rx_valid_out = 1'b0;
      rx_byte_out  = 8'h00;
   end
   // uart stays busy through the stop bit of each taken byte
   always @(posedge clk_in) begin
      if (tx_valid_in && tx_ready_out) busy_cnt <= 4;
      else if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
   end
   assign tx_ready_out = !stall_in && (busy_cnt == 0);
   assign tx_busy_out  = (busy_cnt != 0);
   // caller waits for a quiet bus first; bytes three clocks apart stay far inside the gap
   task automatic send(input logic [7:0] f[$]);
      foreach (f[i]) begin
         @(posedge clk_in);
         #1 rx_valid_out = 1'b1;
         rx_byte_out = f[i];
         @(posedge clk_in);
         #1 rx_valid_out = 1'b0;
         rx_byte_out = ~f[i]; // stale byte never repeats
         @(posedge clk_in);
      end
   endtask
endmodule // mrsf_host_model
`default_nettype wire

/* tb_modbus_rtu_slave_framer.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
   $display("mismatch at %0t got %h expected %h", $time, a, b); end end
module tb_modbus_rtu_slave_framer;
   import mrsf_pkg::*;
   localparam logic [15:0] BAUD = 16'h0002;
   logic clk_in = 1'b0, sys_rst_in = 1'b1, remote = 1'b0, acc_ok = 1'b1;
   logic stall = 1'b0, hold = 1'b0, acc_write, exp_wr = 1'b0;
   logic [1:0] css = 2'h0;
   logic [15:0] key = 16'h0000;
   logic [31:0] seed = 32'h46cf, exp_w = 32'h0;
   logic rx_valid, tx_valid, tx_ready, tx_busy, tx_en, acc_valid, wr_strobe, fault_rst;
   logic [7:0] rx_byte, tx_byte, exp_b;
   logic [15:0] acc_addr, acc_wdata;
   wire logic [15:0] rdata;
   logic [7:0] exp_q[$];
   int num_errors = 0, total_checks = 0, n_wr = 0, n_fr = 0;
   // ************************************************
   // clock, stimulus helpers, instances
   // ************************************************
   always #12.5 clk_in = ~clk_in;
   assign rdata = acc_addr ^ key; // word tied to its address
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
   endfunction
   function automatic logic [15:0] crc16(input logic [7:0] f[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (f[i]) begin
         c ^= {8'h00, f[i]};
         repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
      return c;
   endfunction
   // random stalls on the reply side, a hold stops the uart so reply bytes wait in the fifo
   always @(posedge clk_in) begin
      #1 seed = lfsr(seed);
      stall = hold | (seed[1:0] == 2'h0);
   end
   mrsf_framer i_mrsf_framer (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(1'b1),
      .own_addr_in(8'h01), .baud_div_in(BAUD), .rx_valid_in(rx_valid), .rx_byte_in(rx_byte),
      .tx_valid_out(tx_valid), .tx_byte_out(tx_byte), .tx_ready_in(tx_ready),
      .tx_busy_in(tx_busy), .tx_en_out(tx_en), .remote_mode_in(remote),
      .command_source_select_in(css), .acc_valid_out(acc_valid), .acc_write_out(acc_write),
      .acc_addr_out(acc_addr), .acc_wdata_out(acc_wdata), .acc_rdata_in(rdata),
      .acc_ok_in(acc_ok), .wr_strobe_out(wr_strobe), .fault_reset_out(fault_rst));
   mrsf_host_model i_mrsf_host_model (.clk_in(clk_in), .tx_valid_in(tx_valid),
      .stall_in(stall), .rx_valid_out(rx_valid), .rx_byte_out(rx_byte),
      .tx_ready_out(tx_ready), .tx_busy_out(tx_busy));
   // ************************************************
   // monitor: each reply byte against the oldest note
   // ************************************************
   always @(posedge clk_in) begin
      if (wr_strobe === 1'b1) n_wr++;
      if (fault_rst === 1'b1) n_fr++;
      if (wr_strobe === 1'b1) `CHK({acc_addr, acc_wdata}, exp_w)
      if (acc_valid === 1'b1) `CHK(acc_write, exp_wr)
      if (tx_valid === 1'b1 && tx_ready) begin
         if (exp_q.size() == 0) `CHK(tx_byte, 8'hxx)
         else begin
            exp_b = exp_q.pop_front();
            `CHK(tx_byte, exp_b)
         end
      end
   end
   task automatic final_report();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // kind: 0 silent, 1 echo, 2 read reply, 3 error reply with code ec
   task automatic xfer(input logic [7:0] sta, fn, input logic [15:0] a, v,
                       input int kind, input logic [7:0] ec, input bit bad, input int wr, fr);
      logic [7:0] f[$], r[$];
      logic [15:0] c;
      int n;
      f = {sta, fn, a[15:8], a[7:0], v[15:8], v[7:0]};
      c = crc16(f);
      f.push_back(c[7:0]);
      f.push_back(c[15:8] ^ {7'h00, bad});
      exp_w = {a, v};
      exp_wr = fn == 8'h06;
      if (kind == 1) r = f;
      if (kind == 2) r = {8'h01, fn, 8'(2 * v)};
      for (int i = 0; kind == 2 && i < v; i++) begin
         c = (a + 16'(i)) ^ key;
         r.push_back(c[15:8]);
         r.push_back(c[7:0]);
      end
      if (kind == 3) r = {8'h01, fn | 8'h80, ec};
      c = crc16(r);
      if (kind > 1) r.push_back(c[7:0]);
      if (kind > 1) r.push_back(c[15:8]);
      for (n = 0; tx_en !== 1'b0 && n < 500; n++) @(posedge clk_in);
      if (n >= 500) begin
         num_errors++;
         final_report();
      end
      n_wr = 0;
      n_fr = 0;
      exp_q = r;
      hold = 1'b1;
      i_mrsf_host_model.send(f);
      repeat (39 * BAUD - 6) @(posedge clk_in);
      `CHK({tx_en, acc_valid}, 2'b00)
      `CHK(exp_q.size(), r.size())
      repeat (40) @(posedge clk_in);
      `CHK(tx_en, kind != 0)
      #1 hold = 1'b0;
      for (n = 0; (exp_q.size() != 0 || tx_en !== 1'b0) && n < 2000; n++) @(posedge clk_in);
      `CHK(exp_q.size(), 0)
      `CHK(tx_en, 1'b0)
      `CHK(n_wr, wr)
      `CHK(n_fr, fr)
      if (n >= 2000) final_report();
   endtask
   // ************************************************
   // main sequence
   // ************************************************
   initial begin
      repeat (20) @(posedge clk_in);
      #1 sys_rst_in = 1'b0;
      `CHK({tx_valid, acc_valid, wr_strobe, fault_rst}, 4'h0)
      xfer(8'h01, 8'h03, 16'h0008, 16'h0001, 2, 8'h00, 0, 0, 0);
      xfer(8'h01, 8'h03, 16'h0100, 16'h0005, 2, 8'h00, 0, 0, 0);
      xfer(8'h01, 8'h03, 16'h0100, 16'h0006, 3, 8'h03, 0, 0, 0);
      xfer(8'h01, 8'h06, 16'h0008, 16'h1324, 1, 8'h00, 0, 1, 0);
      xfer(8'h00, 8'h06, 16'h0009, 16'h0042, 0, 8'h00, 0, 1, 0);
      xfer(8'h01, 8'h06, 16'h0009, 16'h0042, 0, 8'h00, 1, 0, 0);
      xfer(8'h02, 8'h03, 16'h0009, 16'h0001, 0, 8'h00, 0, 0, 0);
      xfer(8'h01, 8'h05, 16'h0009, 16'h0001, 3, 8'h01, 0, 0, 0);
      acc_ok = 1'b0;
      xfer(8'h01, 8'h06, 16'h0009, 16'h0042, 3, 8'h04, 0, 0, 0);
      xfer(8'h01, 8'h03, 16'h0009, 16'h0001, 3, 8'h02, 0, 0, 0);
      acc_ok = 1'b1;
      xfer(8'h01, 8'h06, 16'h2000, 16'h0001, 3, 8'h04, 0, 0, 0);
      remote = 1'b1;
      css = 2'h2;
      xfer(8'h01, 8'h06, 16'h2000, 16'h0001, 1, 8'h00, 0, 0, 1);
      css = 2'h1;
      xfer(8'h01, 8'h06, 16'h2000, 16'h0001, 3, 8'h04, 0, 0, 0);
      for (int i = 0; i < 3; i++) begin
         key = seed[31:16];
         xfer(8'h01, 8'h03, seed[15:0] & 16'h1fff, 16'(seed[3:0] % 5 + 1), 2, 8'h00, 0, 0, 0);
         xfer(8'h01, 8'h06, seed[15:0] & 16'h1fff, seed[31:16], 1, 8'h00, 0, 1, 0);
      end
      final_report();
   end
endmodule // tb_modbus_rtu_slave_framer
`default_nettype wire
